// File: tsj_map.vh
// tsj_map.vh: register offsets, security word fields, tap codes and reset values
// assumes inclusion by tsj_top.v and the bench; definitions, no logic
`ifndef TSJ_MAP_VH
`define TSJ_MAP_VH
// register offsets (byte addresses, one word each)
`define TSJ_REG_SEC       8'h00
`define TSJ_REG_STATUS    8'h04
`define TSJ_REG_CTRL      8'h08
`define TSJ_REG_PADDR     8'h0C
`define TSJ_REG_PDATA     8'h10
`define TSJ_REG_PCMD      8'h14
// security word bit positions
`define TSJ_SB_NO_JTAG    0
`define TSJ_SB_NO_LINK    1
`define TSJ_SB_SEC_BOOT   5
`define TSJ_SB_REDUND     7
`define TSJ_SB_LOCK0      8
`define TSJ_SB_MASTER     12
`define TSJ_SB_NO_JOTP    13
`define TSJ_SB_NO_DBG     14
`define TSJ_SB_GP_HI      21
`define TSJ_SB_GP_LO      15
`define TSJ_SB_UID_HI     31
`define TSJ_SB_UID_LO     22
// status and control bits
`define TSJ_ST_LOADED     0
`define TSJ_ST_DBG        1
`define TSJ_ST_PREJ       2
`define TSJ_ST_JREJ       3
`define TSJ_CT_DOUT       0
`define TSJ_CT_DIN        1
`define TSJ_PC_GO         0
`define TSJ_PC_SECW       1
// otp geometry: address = {sector[1:0], row[8:0]}
`define TSJ_OTP_AW        11
`define TSJ_SEC_HI        10
`define TSJ_SEC_LO        9
`define TSJ_SEC_ROW       11'h7FF
// tap states
`define TSJ_T_RESET       4'h0
`define TSJ_T_IDLE        4'h1
`define TSJ_T_SELDR       4'h2
`define TSJ_T_CAPDR       4'h3
`define TSJ_T_SHDR        4'h4
`define TSJ_T_EX1DR       4'h5
`define TSJ_T_PAUDR       4'h6
`define TSJ_T_EX2DR       4'h7
`define TSJ_T_UPDR        4'h8
`define TSJ_T_SELIR       4'h9
`define TSJ_T_CAPIR       4'hA
`define TSJ_T_SHIR        4'hB
`define TSJ_T_EX1IR       4'hC
`define TSJ_T_PAUIR       4'hD
`define TSJ_T_EX2IR       4'hE
`define TSJ_T_UPIR        4'hF
// instructions, 4 bits per tap
`define TSJ_I_EXTEST      4'h0
`define TSJ_I_SAMPLE      4'h1
`define TSJ_I_IDCODE      4'h2
`define TSJ_I_USERCODE    4'h3
`define TSJ_I_TILE        4'h4
`define TSJ_I_OTP         4'h5
`define TSJ_I_BYPASS      4'hF
`define TSJ_IR_CAPT       4'h1
// data register lengths
`define TSJ_DRW           45
`define TSJ_LEN_BYP       6'd1
`define TSJ_LEN_WORD      6'd32
`define TSJ_LEN_OTP       6'd44
// synchroniser reset: debug pin idle high, test reset asserted, tck low
`define TSJ_SYNC_RST      4'h8
`endif

// File: tsj_top.v
// tsj_top.v: per-tile security word, two-tap jtag chain, debug sync pin, otp guard
// assumes one core clock, jtag pins asynchronous to it; otp and tile ports on core_clk
//
// Contract
// - security bit 0 set: chip tap refuses tile and memory access
// - security bit 1 set: link requests to processor state are denied
// - security bit 5 set: boot from otp address 0, skipping boot rom
// - security bit 7 set: redundant otp rows enabled
// - bits 8..11 each lock programming of otp sectors 0..3
// - bit 12 set: every otp programming, security word included, is rejected
// - bit 13 set: jtag reads and writes of otp are blocked
// - bit 14 set: debug sync pin is neither driven nor obeyed
// - bits 21..15 are a general field readable by software
// - bits 31..22 are a user field extending the jtag user code
// - after reset the chain holds a boundary tap and a chip tap
// - boundary tap follows 1149.1 and scans the i/o pins
// - chip tap reaches tile, switch and otp for loading and debug; here it reaches tile and otp only, no switch
// - test reset low keeps the jtag logic in reset
// - debug pin tri-stated until a breakpoint, then driven low
// - external low on debug pin puts the tile in debug mode
// - idcode is version, part number, maker identity, then a one
// - usercode is user field, unused field, silicon revision
// - security word loads from otp before its controls act
// - otp is four sectors of 512 rows of 32 bits
//
// Chosen here: strobed register access and the register offsets.
`timescale 1ns/1ns
`include "tsj_map.vh"

module tsj_top #(
  parameter BSR_W    = 8,
  parameter [3:0]  ID_VER  = 4'h1,     // arbitrary value
  parameter [15:0] ID_PART = 16'h0ABC, // arbitrary value
  parameter [10:0] ID_MFR  = 11'h155,  // arbitrary value
  parameter [15:0] SI_REV  = 16'h0001  // arbitrary value
) (
  // clock and reset
  input  wire              core_clk,
  input  wire              rst,
  // register port
  input  wire [7:0]        reg_addr,
  input  wire [31:0]       reg_wdata,
  input  wire              reg_wr,
  input  wire              reg_rd,
  output reg  [31:0]       reg_rdata,
  // otp read and program port
  output reg               otp_rd_req,
  output reg  [10:0]       otp_rd_addr,
  input  wire              otp_rd_valid,
  input  wire [31:0]       otp_rd_data,
  output reg               otp_prog_req,
  output reg  [10:0]       otp_prog_addr,
  output reg  [31:0]       otp_prog_data,
  output reg               otp_prog_secw,
  // security controls to the tile
  output reg               sec_valid,
  output reg               boot_from_otp,
  output reg               redund_rows_en,
  // link access to processor state
  input  wire              link_req,
  output reg               link_grant,
  output reg               link_deny,
  // jtag access to the tile
  output reg               jtag_tile_wr,
  output reg  [31:0]       jtag_tile_data,
  input  wire [31:0]       tile_rdata,
  // jtag pins
  input  wire              tck,
  input  wire              tms,
  input  wire              tdi,
  input  wire              trst_n,
  output reg               tdo_out,
  output reg               tdo_oe_n,
  // boundary scan cells
  input  wire [BSR_W-1:0]  bs_pin_in,
  output reg  [BSR_W-1:0]  bs_pin_out,
  output reg               bs_drive_n,
  // debug sync pin and processor debug
  input  wire              dbg_pin_in,
  output reg               dbg_pin_out,
  output reg               dbg_pin_oe_n,
  input  wire              break_hit,
  input  wire              debug_exit,
  output reg               debug_enter
);

  // pin synchronisers: stage 1 is read only by stage 2
  reg [3:0]       s1_r;
  reg [3:0]       s2_r;
  reg             tck_d_r;
  reg [BSR_W-1:0] bs1_r;
  reg [BSR_W-1:0] bs2_r;
  always @(posedge core_clk) begin
    if (rst) begin
      s1_r    <= `TSJ_SYNC_RST;  // tck low matches tck_d_r, so no false edge
      s2_r    <= `TSJ_SYNC_RST;  // test reset reads asserted until the pin is seen
      tck_d_r <= 1'b0;
      bs1_r   <= {BSR_W{1'b0}};
      bs2_r   <= {BSR_W{1'b0}};
    end else begin
      s1_r    <= {dbg_pin_in, trst_n, tdi, tck};
      s2_r    <= s1_r;
      tck_d_r <= s2_r[0];
      bs1_r   <= bs_pin_in;
      bs2_r   <= bs1_r;
    end
  end
  wire tck_rise = s2_r[0] & ~tck_d_r;
  wire tck_fall = ~s2_r[0] & tck_d_r;
  wire tdi_s    = s2_r[1];
  wire trst_s_n = s2_r[2];
  wire dbg_s    = s2_r[3];
  // tms is only taken on a tck edge, well after it settled; two flops keep it safe
  reg tms1_r;
  reg tms2_r;
  always @(posedge core_clk) begin
    if (rst) begin
      tms1_r <= 1'b1;
      tms2_r <= 1'b1;
    end else begin
      tms1_r <= tms;
      tms2_r <= tms1_r;
    end
  end

  // security word load at power-up, before any control acts
  reg [31:0] sec_r;
  reg        loaded_r;
  reg        ld_busy_r;
  always @(posedge core_clk) begin
    if (rst) begin
      sec_r     <= 32'h0000_0000;
      loaded_r  <= 1'b0;
      ld_busy_r <= 1'b0;
    end else if (!loaded_r) begin
      if (!ld_busy_r) begin
        ld_busy_r <= 1'b1;
      end else if (otp_rd_valid) begin
        sec_r     <= otp_rd_data;
        loaded_r  <= 1'b1;
        ld_busy_r <= 1'b0;
      end
    end
  end
  wire sb_no_jtag = sec_r[`TSJ_SB_NO_JTAG];
  wire sb_no_jotp = sec_r[`TSJ_SB_NO_JOTP];
  wire sb_no_dbg  = sec_r[`TSJ_SB_NO_DBG];
  wire sb_master  = sec_r[`TSJ_SB_MASTER];

  // tile-facing controls, inactive until the word is in
  always @(posedge core_clk) begin
    if (rst) begin
      sec_valid      <= 1'b0;
      boot_from_otp  <= 1'b0;
      redund_rows_en <= 1'b0;
    end else begin
      sec_valid      <= loaded_r;
      boot_from_otp  <= loaded_r & sec_r[`TSJ_SB_SEC_BOOT];
      redund_rows_en <= loaded_r & sec_r[`TSJ_SB_REDUND];
    end
  end

  // link access: a request waits while the load runs, then is judged
  reg link_pend_r;
  always @(posedge core_clk) begin
    if (rst) begin
      link_pend_r <= 1'b0;
      link_grant  <= 1'b0;
      link_deny   <= 1'b0;
    end else begin
      link_grant <= 1'b0;
      link_deny  <= 1'b0;
      if (loaded_r && (link_req || link_pend_r)) begin
        link_pend_r <= 1'b0;
        link_grant  <= ~sec_r[`TSJ_SB_NO_LINK];
        link_deny   <= sec_r[`TSJ_SB_NO_LINK];
      end else if (link_req) begin
        link_pend_r <= 1'b1;
      end
    end
  end

  // tap controller, shared by both taps since they see the same tms
  reg [3:0] tst_r;
  reg [3:0] tst_nxt;
  always @* begin
    case (tst_r)
      `TSJ_T_RESET: tst_nxt = tms2_r ? `TSJ_T_RESET : `TSJ_T_IDLE;
      `TSJ_T_IDLE:  tst_nxt = tms2_r ? `TSJ_T_SELDR : `TSJ_T_IDLE;
      `TSJ_T_SELDR: tst_nxt = tms2_r ? `TSJ_T_SELIR : `TSJ_T_CAPDR;
      `TSJ_T_CAPDR: tst_nxt = tms2_r ? `TSJ_T_EX1DR : `TSJ_T_SHDR;
      `TSJ_T_SHDR:  tst_nxt = tms2_r ? `TSJ_T_EX1DR : `TSJ_T_SHDR;
      `TSJ_T_EX1DR: tst_nxt = tms2_r ? `TSJ_T_UPDR  : `TSJ_T_PAUDR;
      `TSJ_T_PAUDR: tst_nxt = tms2_r ? `TSJ_T_EX2DR : `TSJ_T_PAUDR;
      `TSJ_T_EX2DR: tst_nxt = tms2_r ? `TSJ_T_UPDR  : `TSJ_T_SHDR;
      `TSJ_T_UPDR:  tst_nxt = tms2_r ? `TSJ_T_SELDR : `TSJ_T_IDLE;
      `TSJ_T_SELIR: tst_nxt = tms2_r ? `TSJ_T_RESET : `TSJ_T_CAPIR;
      `TSJ_T_CAPIR: tst_nxt = tms2_r ? `TSJ_T_EX1IR : `TSJ_T_SHIR;
      `TSJ_T_SHIR:  tst_nxt = tms2_r ? `TSJ_T_EX1IR : `TSJ_T_SHIR;
      `TSJ_T_EX1IR: tst_nxt = tms2_r ? `TSJ_T_UPIR  : `TSJ_T_PAUIR;
      `TSJ_T_PAUIR: tst_nxt = tms2_r ? `TSJ_T_EX2IR : `TSJ_T_PAUIR;
      `TSJ_T_EX2IR: tst_nxt = tms2_r ? `TSJ_T_UPIR  : `TSJ_T_SHIR;
      `TSJ_T_UPIR:  tst_nxt = tms2_r ? `TSJ_T_SELDR : `TSJ_T_IDLE;
      default:      tst_nxt = `TSJ_T_RESET;
    endcase
  end
  wire jrst = rst | ~trst_s_n;

  // chain order: tdi -> boundary tap -> chip tap -> tdo
  reg  [3:0]         ir_bs_r;
  reg  [3:0]         ir_ch_r;
  reg  [3:0]         irs_bs_r;
  reg  [3:0]         irs_ch_r;
  reg  [`TSJ_DRW-1:0] dr_bs_r;
  reg  [`TSJ_DRW-1:0] dr_ch_r;
  reg  [`TSJ_DRW-1:0] dr_bs_nxt;
  reg  [`TSJ_DRW-1:0] dr_ch_nxt;
  reg  [5:0]         len_bs;
  reg  [5:0]         len_ch;
  reg  [31:0]        jotp_rdata_r;
  wire [31:0]        idcode = {ID_VER, ID_PART, ID_MFR, 1'b1};
  wire [31:0]        ucode  = {sec_r[`TSJ_SB_UID_HI:`TSJ_SB_UID_LO], 6'h00, SI_REV};
  wire               ch_open = loaded_r & ~sb_no_jtag;
  wire               otp_open = ch_open & ~sb_no_jotp;

  // data register lengths by instruction
  always @* begin
    case (ir_bs_r)
      `TSJ_I_EXTEST, `TSJ_I_SAMPLE: len_bs = BSR_W[5:0];
      `TSJ_I_IDCODE:                len_bs = `TSJ_LEN_WORD;
      default:                      len_bs = `TSJ_LEN_BYP;
    endcase
    case (ir_ch_r)
      `TSJ_I_IDCODE, `TSJ_I_USERCODE, `TSJ_I_TILE: len_ch = `TSJ_LEN_WORD;
      `TSJ_I_OTP:                   len_ch = `TSJ_LEN_OTP + 6'd1;
      default:                      len_ch = `TSJ_LEN_BYP;
    endcase
  end

  // shift step: each register shifts right and takes its input at its own top bit
  always @* begin
    dr_bs_nxt = dr_bs_r >> 1;
    dr_ch_nxt = dr_ch_r >> 1;
    dr_bs_nxt[len_bs-6'd1] = tdi_s;
    dr_ch_nxt[len_ch-6'd1] = dr_bs_r[0];
  end

  // tap registers, stepped on each sampled rising tck edge
  reg upd_ch_r;
  always @(posedge core_clk) begin
    if (jrst) begin
      tst_r    <= `TSJ_T_RESET;
      ir_bs_r  <= `TSJ_I_IDCODE;
      ir_ch_r  <= `TSJ_I_IDCODE;
      irs_bs_r <= `TSJ_IR_CAPT;
      irs_ch_r <= `TSJ_IR_CAPT;
      dr_bs_r  <= {`TSJ_DRW{1'b0}};
      dr_ch_r  <= {`TSJ_DRW{1'b0}};
      upd_ch_r <= 1'b0;
      bs_pin_out <= {BSR_W{1'b0}};
      bs_drive_n <= 1'b1;
    end else begin
      upd_ch_r <= 1'b0;
      if (tck_rise) begin
        tst_r <= tst_nxt;
        case (tst_r)
          `TSJ_T_RESET: begin
            ir_bs_r <= `TSJ_I_IDCODE;
            ir_ch_r <= `TSJ_I_IDCODE;
          end
          `TSJ_T_CAPIR: begin
            irs_bs_r <= `TSJ_IR_CAPT;
            irs_ch_r <= `TSJ_IR_CAPT;
          end
          `TSJ_T_SHIR: begin
            irs_bs_r <= {tdi_s, irs_bs_r[3:1]};
            irs_ch_r <= {irs_bs_r[0], irs_ch_r[3:1]};
          end
          `TSJ_T_UPIR: begin
            ir_bs_r <= irs_bs_r;
            ir_ch_r <= irs_ch_r;
          end
          `TSJ_T_CAPDR: begin
            dr_bs_r <= (len_bs == `TSJ_LEN_WORD) ? {13'h0000, idcode} :
                       (len_bs == `TSJ_LEN_BYP) ? {`TSJ_DRW{1'b0}} :
                       {{(`TSJ_DRW-BSR_W){1'b0}}, bs2_r};
            case (ir_ch_r)
              `TSJ_I_IDCODE:   dr_ch_r <= {13'h0000, idcode};
              `TSJ_I_USERCODE: dr_ch_r <= {13'h0000, ucode};
              `TSJ_I_TILE:     dr_ch_r <= {13'h0000, ch_open ? tile_rdata : 32'h0000_0000};
              `TSJ_I_OTP:      dr_ch_r <= {13'h0000, otp_open ? jotp_rdata_r : 32'h0000_0000};
              default:         dr_ch_r <= {`TSJ_DRW{1'b0}};
            endcase
          end
          `TSJ_T_SHDR: begin
            dr_bs_r <= dr_bs_nxt;
            dr_ch_r <= dr_ch_nxt;
          end
          `TSJ_T_UPDR: begin
            if (ir_bs_r == `TSJ_I_EXTEST) begin
              bs_pin_out <= dr_bs_r[BSR_W-1:0];
            end
            upd_ch_r <= (ir_ch_r == `TSJ_I_TILE) || (ir_ch_r == `TSJ_I_OTP);
          end
          default: begin
          end
        endcase
      end
      bs_drive_n <= ~(ir_bs_r == `TSJ_I_EXTEST);
    end
  end

  // tdo changes on the falling tck edge, driven only while shifting
  always @(posedge core_clk) begin
    if (jrst) begin
      tdo_out  <= 1'b0;
      tdo_oe_n <= 1'b1;
    end else if (tck_fall) begin
      tdo_out  <= (tst_r == `TSJ_T_SHIR) ? irs_ch_r[0] : dr_ch_r[0];
      tdo_oe_n <= ~((tst_r == `TSJ_T_SHIR) || (tst_r == `TSJ_T_SHDR));
    end
  end

  // software programming registers and control
  reg [31:0] ctrl_r;
  reg [10:0] paddr_r;
  reg [31:0] pdata_r;
  reg        prej_r;
  reg        jrej_r;
  reg        dbg_mode_r;
  wire       sw_go   = reg_wr && (reg_addr == `TSJ_REG_PCMD) && reg_wdata[`TSJ_PC_GO];
  wire       sw_secw = reg_wdata[`TSJ_PC_SECW];
  // jtag requests from the chip tap, held while the load runs
  reg        jt_pend_r;
  wire       jt_go   = loaded_r & (upd_ch_r | jt_pend_r);
  wire       jt_otp  = (ir_ch_r == `TSJ_I_OTP);
  wire       jt_wr   = dr_ch_r[`TSJ_LEN_OTP];
  wire [1:0] jt_sect = dr_ch_r[32+`TSJ_SEC_HI:32+`TSJ_SEC_LO];
  wire [1:0] sw_sect = paddr_r[`TSJ_SEC_HI:`TSJ_SEC_LO];
  // sector lock lookup, one bit per sector
  wire [3:0] lock = sec_r[`TSJ_SB_LOCK0+3:`TSJ_SB_LOCK0];
  wire       sw_ok = ~sb_master & (sw_secw | ~lock[sw_sect]);
  wire       jt_ok = otp_open & ~sb_master & ~lock[jt_sect];
  wire       jt_ev_rej = jt_go & ((jt_otp & ~(jt_wr ? jt_ok : otp_open)) | (~jt_otp & ~ch_open));
  // otp program and jtag read requests; software wins a same-cycle clash
  always @(posedge core_clk) begin
    if (rst) begin
      otp_prog_req  <= 1'b0;
      otp_prog_addr <= 11'h000;
      otp_prog_data <= 32'h0000_0000;
      otp_prog_secw <= 1'b0;
      otp_rd_req    <= 1'b0;
      otp_rd_addr   <= `TSJ_SEC_ROW;
      jotp_rdata_r  <= 32'h0000_0000;
      jt_pend_r     <= 1'b0;
      jtag_tile_wr  <= 1'b0;
      jtag_tile_data <= 32'h0000_0000;
    end else begin
      otp_prog_req <= 1'b0;
      otp_rd_req   <= ~loaded_r & ~ld_busy_r;
      jtag_tile_wr <= 1'b0;
      if (upd_ch_r && !loaded_r) begin
        jt_pend_r <= 1'b1;
      end else if (jt_go) begin
        jt_pend_r <= 1'b0;
      end
      if (loaded_r && otp_rd_valid) begin
        jotp_rdata_r <= otp_rd_data;
      end
      if (sw_go && loaded_r) begin
        otp_prog_req  <= sw_ok;
        otp_prog_addr <= sw_secw ? `TSJ_SEC_ROW : paddr_r;
        otp_prog_data <= pdata_r;
        otp_prog_secw <= sw_secw;
      end else if (jt_go && jt_otp && jt_wr) begin
        otp_prog_req  <= jt_ok;
        otp_prog_addr <= dr_ch_r[32+`TSJ_OTP_AW-1:32];
        otp_prog_data <= dr_ch_r[31:0];
        otp_prog_secw <= 1'b0;
      end
      if (jt_go && jt_otp && !jt_wr && otp_open) begin
        otp_rd_req  <= 1'b1;
        otp_rd_addr <= dr_ch_r[32+`TSJ_OTP_AW-1:32];
      end else if (!loaded_r) begin
        otp_rd_addr <= `TSJ_SEC_ROW;
      end
      if (jt_go && !jt_otp && ch_open) begin
        jtag_tile_wr   <= 1'b1;
        jtag_tile_data <= dr_ch_r[31:0];
      end
    end
  end

  // debug sync pin: drive low on a breakpoint, obey an external low
  reg dbg_d_r;
  always @(posedge core_clk) begin
    if (rst) begin
      dbg_d_r      <= 1'b1;
      dbg_pin_out  <= 1'b0;
      dbg_pin_oe_n <= 1'b1;
      debug_enter  <= 1'b0;
      dbg_mode_r   <= 1'b0;
    end else begin
      dbg_d_r     <= dbg_s;
      debug_enter <= 1'b0;
      if (!loaded_r || sb_no_dbg) begin
        dbg_pin_oe_n <= 1'b1;
      end else if (ctrl_r[`TSJ_CT_DOUT] && break_hit) begin
        dbg_pin_oe_n <= 1'b0;
      end else if (debug_exit || !ctrl_r[`TSJ_CT_DOUT]) begin
        dbg_pin_oe_n <= 1'b1;
      end
      if (loaded_r && !sb_no_dbg && ctrl_r[`TSJ_CT_DIN] && !dbg_s && dbg_d_r && !dbg_mode_r) begin
        debug_enter <= 1'b1;
        dbg_mode_r  <= 1'b1;
      end else if (break_hit) begin
        dbg_mode_r  <= 1'b1;
      end else if (debug_exit) begin
        dbg_mode_r  <= 1'b0;
      end
    end
  end

  // register writes; sticky reject flags: set wins over a write-one clear
  always @(posedge core_clk) begin
    if (rst) begin
      ctrl_r  <= 32'h0000_0000;
      paddr_r <= 11'h000;
      pdata_r <= 32'h0000_0000;
      prej_r  <= 1'b0;
      jrej_r  <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == `TSJ_REG_CTRL) begin
        ctrl_r <= {30'h0000_0000, reg_wdata[1:0]};
      end
      if (reg_wr && reg_addr == `TSJ_REG_PADDR) begin
        paddr_r <= reg_wdata[`TSJ_OTP_AW-1:0];
      end
      if (reg_wr && reg_addr == `TSJ_REG_PDATA) begin
        pdata_r <= reg_wdata;
      end
      if ((sw_go && (!loaded_r || !sw_ok)) || (jt_go && jt_otp && jt_wr && !jt_ok)) begin
        prej_r <= 1'b1;
      end else if (reg_wr && reg_addr == `TSJ_REG_STATUS && reg_wdata[`TSJ_ST_PREJ]) begin
        prej_r <= 1'b0;
      end
      if (jt_ev_rej) begin
        jrej_r <= 1'b1;
      end else if (reg_wr && reg_addr == `TSJ_REG_STATUS && reg_wdata[`TSJ_ST_JREJ]) begin
        jrej_r <= 1'b0;
      end
    end
  end

  // read data, one cycle after the strobe; unmapped reads give zero
  always @(posedge core_clk) begin
    if (rst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `TSJ_REG_SEC:    reg_rdata <= sec_r;
        `TSJ_REG_STATUS: reg_rdata <= {28'h0000000, jrej_r, prej_r, dbg_mode_r, loaded_r};
        `TSJ_REG_CTRL:   reg_rdata <= ctrl_r;
        `TSJ_REG_PADDR:  reg_rdata <= {21'h000000, paddr_r};
        `TSJ_REG_PDATA:  reg_rdata <= pdata_r;
        default:         reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

endmodule // tsj_top

// File: tsj_otp_mdl.sv
// tsj_otp_mdl.sv: otp memory that answers the security word read
// assumes one read after each reset, answered lat+1 cycles later
`timescale 1ns/1ns
module tsj_otp_mdl (
  // clock and reset
  input  wire        core_clk,
  input  wire        rst,
  // read port
  input  wire        otp_rd_req,
  output reg         otp_rd_valid = 1'b0,
  output reg  [31:0] otp_rd_data = 32'h00000000,
  // stored security row and answer delay
  input  wire [31:0] word,
  input  wire [2:0]  lat
);
  reg [3:0] cnt_r = 4'h0;
  // idle data toggles so a stale word never passes for an answer
  always @(posedge core_clk) begin
    otp_rd_valid <= 1'b0;
    otp_rd_data  <= ~otp_rd_data;
    if (rst)
      cnt_r <= 4'h0;
    else if (otp_rd_req)
      cnt_r <= {1'b0, lat} + 4'h1;
    else if (cnt_r != 4'h0)
      cnt_r <= cnt_r - 4'h1;
    if (!rst && cnt_r == 4'h1) begin
      otp_rd_valid <= 1'b1;
      otp_rd_data  <= word;
    end
  end
endmodule // tsj_otp_mdl

// File: tsj_top_sva.sv
// tsj_top_sva.sv: port checker for the tile security block
// assumes one core_clk domain; the word is copied off the otp bus
`timescale 1ns/1ns
module tsj_top_sva (
  // clock and reset
  input wire logic        core_clk, rst,
  // otp and security outputs
  input wire logic        otp_rd_valid, otp_prog_req, otp_prog_secw,
  input wire logic [31:0] otp_rd_data,
  input wire logic [10:0] otp_prog_addr,
  input wire logic        sec_valid, boot_from_otp, redund_rows_en,
  // link, jtag and debug pin
  input wire logic        link_req, link_grant, link_deny, trst_n, tdo_oe_n,
  input wire logic        dbg_pin_oe_n, break_hit, debug_enter
);
  reg [31:0] sw_r;
  // only the load read arrives while the word is not yet valid
  always @(posedge core_clk) begin
    if (otp_rd_valid && !sec_valid)
      sw_r <= otp_rd_data;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  chk_boot_bit: assert property (sec_valid |-> boot_from_otp == sw_r[5])
    else $error("boot select differs from word");
  chk_redund_bit: assert property (sec_valid |-> redund_rows_en == sw_r[7])
    else $error("redundant rows differ from word");
  chk_load_first: assert property (!sec_valid |-> !otp_prog_req && !link_grant && !link_deny)
    else $error("action before word load");
  chk_link_answer: assert property (link_req && sec_valid |=> link_grant != link_deny)
    else $error("link request not answered");
  chk_link_grant: assert property (link_grant |-> !sw_r[1])
    else $error("link granted while blocked");
  chk_prog_lock: assert property (otp_prog_req |-> !sw_r[12] &&
    (otp_prog_secw || !sw_r[8 + otp_prog_addr[10:9]]))
    else $error("locked otp programmed");
  chk_dbg_off: assert property (sec_valid && sw_r[14] |-> dbg_pin_oe_n && !debug_enter)
    else $error("debug pin used while disabled");
  chk_dbg_drive: assert property ($fell(dbg_pin_oe_n) |-> $past(break_hit))
    else $error("debug pin driven without breakpoint");
  chk_trst_hold: assert property (!trst_n [*5] |-> tdo_oe_n)
    else $error("tdo driven in test reset");
endmodule // tsj_top_sva
bind tsj_top tsj_top_sva u_sva (.*);

// File: tb_tile_security_and_jtag_access.sv
// tb_tile_security_and_jtag_access.sv: self-checking bench for tsj_top
// assumes tsj_otp_mdl as otp, a pulled-up debug pin and default ids
`timescale 1ns/1ns
`include "tsj_map.vh"
`define CHK(n, e, g) begin check_count = check_count + 1; if ((g) !== (e)) begin \
  error_cnt = error_cnt + 1; $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module tb_tile_security_and_jtag_access;
  reg         clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, link_req = 0;
  reg         tck = 0, tms = 1, trst_n = 0, brk = 0, dx = 0, dbg_ext = 1;
  reg  [7:0]  reg_addr = 8'h00;
  reg  [31:0] reg_wdata = 32'h0, w = 32'h0, v;
  reg  [2:0]  lat = 3'h0;
  wire [31:0] reg_rdata, rdd;
  wire        rq, rv, pq, sv, bt, rr, lg, ld, tdo, dout, doe, de;
  integer     seed = 9269, error_cnt = 0, check_count = 0, cyc = 0;
  integer     k, s, i, e0, pc = 0, gc = 0, dc = 0, ec = 0;
  // pull-up holds the pin high unless the device or dbg_ext pulls it low
  wire        dbg_wire = doe ? dbg_ext : dout;
  tsj_top DUT (.core_clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .otp_rd_req(rq), .otp_rd_addr(), .otp_rd_valid(rv),
    .otp_rd_data(rdd), .otp_prog_req(pq), .otp_prog_addr(), .otp_prog_data(), .otp_prog_secw(),
    .sec_valid(sv), .boot_from_otp(bt), .redund_rows_en(rr), .link_req(link_req), .link_grant(lg),
    .link_deny(ld), .jtag_tile_wr(), .jtag_tile_data(), .tile_rdata(32'h0), .tck(tck), .tms(tms),
    .tdi(1'b0), .trst_n(trst_n), .tdo_out(tdo), .tdo_oe_n(), .bs_pin_in(8'h00), .bs_pin_out(),
    .bs_drive_n(), .dbg_pin_in(dbg_wire), .dbg_pin_out(dout), .dbg_pin_oe_n(doe), .break_hit(brk),
    .debug_exit(dx), .debug_enter(de));
  tsj_otp_mdl u_otp (.core_clk(clk), .rst(rst), .otp_rd_req(rq), .otp_rd_valid(rv), .otp_rd_data(rdd),
    .word(w), .lat(lat));
  initial forever #20 clk = ~clk;
  // event counters cleared by reset; the cycle ceiling cuts a hang
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (rst) begin
      pc = 0; gc = 0; dc = 0; ec = 0;
    end else begin
      pc = pc + pq; gc = gc + lg; dc = dc + ld; ec = ec + de;
    end
    if (cyc == 5000) begin
      error_cnt = error_cnt + 1;
      print_verdict;
    end
  end
  task print_verdict; begin
    if (error_cnt == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  end endtask
  task wr(input [7:0] a, input [31:0] d); begin
    @(posedge clk); reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
    @(posedge clk); reg_wr <= 1'b0;
  end endtask
  task rd(input [7:0] a, output [31:0] d); begin
    @(posedge clk); reg_addr <= a; reg_rd <= 1'b1;
    @(posedge clk); reg_rd <= 1'b0;
    #1 d = reg_rdata;
  end endtask
  task idle(input integer n); begin
    repeat (n) @(posedge clk);
    #1;
  end endtask
  // one tck period of 8 clocks, every pin change on a clk edge; tdo taken late in the high phase
  task tick(input m); begin
    tms <= m; repeat (4) @(posedge clk); tck <= 1'b1;
    repeat (3) @(posedge clk); #1 v = {tdo, v[31:1]};
    @(posedge clk); tck <= 1'b0;
  end endtask
  // programs allowed among four sectors plus the security word
  function integer exp_prog(input [31:0] x); integer j; begin
    exp_prog = 0;
    for (j = 0; j < 5; j = j + 1)
      if (!x[12] && (j == 4 || !x[8 + j])) exp_prog = exp_prog + 1;
  end endfunction
  initial begin
    for (k = 0; k < 3; k = k + 1) begin
      @(posedge clk); rst <= 1'b1; trst_n <= 1'b0; lat <= $random(seed);
      w <= (k == 0) ? $random(seed) : (k == 1) ? 32'h00000000 : 32'hFFFFEFFF;
      repeat (3) @(posedge clk); rst <= 1'b0;
      repeat (6) @(posedge clk); trst_n <= 1'b1;
      for (i = 0; i < 40 && sv !== 1'b1; i = i + 1) @(posedge clk);
      #1 `CHK("sec_valid", 1'b1, sv)
      `CHK("boot_from_otp", w[5], bt)
      `CHK("redund_rows_en", w[7], rr)
      rd(`TSJ_REG_SEC, v);
      `CHK("security word", w, v)
      rd(8'h40, v);
      `CHK("unmapped read", 32'h0, v)
      for (s = 0; s < 4; s = s + 1) begin
        wr(`TSJ_REG_PADDR, {s[1:0], 9'h0A5});
        wr(`TSJ_REG_PDATA, $random(seed));
        wr(`TSJ_REG_PCMD, 32'h1);
      end
      wr(`TSJ_REG_PCMD, 32'h3);
      idle(2);
      `CHK("program count", exp_prog(w), pc)
      @(posedge clk); link_req <= 1'b1;
      repeat (2) @(posedge clk); link_req <= 1'b0;
      idle(3);
      `CHK("link grants", 2 * !w[1], gc)
      `CHK("link denies", 2 * w[1], dc)
      wr(`TSJ_REG_CTRL, 32'h1);
      @(posedge clk); brk <= 1'b1;
      @(posedge clk); brk <= 1'b0;
      idle(1);
      `CHK("debug pin enable", w[14], doe)
      @(posedge clk); dx <= 1'b1;
      @(posedge clk); dx <= 1'b0;
      wr(`TSJ_REG_CTRL, 32'h2);
      #1 e0 = ec;
      @(posedge clk); dbg_ext <= 1'b0;
      repeat (8) @(posedge clk); dbg_ext <= 1'b1;
      #1 `CHK("debug entries", !w[14], ec - e0)
      @(posedge clk);
      repeat (5) tick(1'b1);
      tick(1'b0); tick(1'b1); tick(1'b0); tick(1'b0);
      for (i = 0; i < 32; i = i + 1) tick(1'b0);
      `CHK("chip idcode", {4'h1, 16'h0ABC, 11'h155, 1'b1}, v)
      for (i = 0; i < 32; i = i + 1) tick(1'b0);
      `CHK("boundary idcode", {4'h1, 16'h0ABC, 11'h155, 1'b1}, v)
    end
    print_verdict;
  end
endmodule // tb_tile_security_and_jtag_access
